// ==== rtl/tx_restart_interval_timer.sv ====
// APB-facing transmit interval timer with permit restart
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "txit_cfg.svh"
// What this block does
// - 32-bit read/write modulus register sets range
// - Modulus write while running reloads counter
// - Neither or tristate select: free system timer
// - 32-bit read-only current count register
// - Counter runs on selected channel clock
// - Read count synchronised into system domain
// - Timer sets transmit permit again
module tx_restart_interval_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pllTick,
    input wire logic packetEndClear,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic transmitPermit,
    output logic restartPulse
);
    // ----------------------------------------
    // Registers and wires
    // ----------------------------------------
    logic [31:0] txIntervalModulus_r; // Modulus register
    txit_pkg::txit_ctrl_t ctrl_r; // Control fields
    logic reload_r; // One-cycle reload request
    logic [`TXIT_DIV_W-1:0] div_r; // Reference divider
    logic refTick_r; // 32 MHz-rate enable
    logic pllSync1_r; // PLL tick sync first stage
    logic pllSync2_r; // PLL tick sync second stage
    logic pllSync3_r; // PLL tick edge history
    logic pllTick_r; // PLL rising-edge enable
    logic clrSync1_r; // Permit clear sync first stage
    logic clrSync2_r; // Permit clear sync second stage
    logic [31:0] countSync_r; // Count presented to reads
    logic permit_r; // Transmit permit
    logic restart_r; // Restart pulse out
    logic restartSeen_r; // Sticky restart status
    logic [31:0] prdata_r; // Read data
    logic pready_r; // Access ready
    logic pslverr_r; // Access error
    logic tickEn; // Selected channel enable
    logic setup; // APB setup phase
    logic wrStb; // Write strobe in setup
    logic mapped; // Address hits a register
    logic [31:0] rdMux; // Read multiplexer
    logic [31:0] wrMerged; // Byte-merged modulus write
    txit_pkg::txit_core_t core; // Counter core state

    // Setup-phase decode, answered one cycle later
    assign setup = psel && !penable;
    assign wrStb = setup && pwrite && mapped;
    always_comb begin
        unique case (paddr)
            `TXIT_OFS_MODULUS, `TXIT_OFS_COUNT, `TXIT_OFS_CONTROL, `TXIT_OFS_STATUS: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Channel clock enables
    // ----------------------------------------
    // Divider makes the reference-rate enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_r <= '0;
            refTick_r <= 1'b0;
        end else if (div_r == `TXIT_DIV_W'(`TXIT_DIV_CYC - 1)) begin
            div_r <= '0;
            refTick_r <= 1'b1;
        end else begin
            div_r <= div_r + `TXIT_DIV_W'(1);
            refTick_r <= 1'b0;
        end
    end

    // PLL tick synchroniser and edge detector
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pllSync1_r <= 1'b0;
            pllSync2_r <= 1'b0;
            pllSync3_r <= 1'b0;
            pllTick_r <= 1'b0;
        end else begin
            pllSync1_r <= pllTick;
            pllSync2_r <= pllSync1_r;
            pllSync3_r <= pllSync2_r;
            pllTick_r <= pllSync2_r && !pllSync3_r;
        end
    end

    assign tickEn = ctrl_r.usePll ? pllTick_r : refTick_r;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Byte lanes merged into the modulus
    always_comb begin
        wrMerged = txIntervalModulus_r;
        for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
                wrMerged[8*b +: 8] = pwdata[8*b +: 8];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txIntervalModulus_r <= `TXIT_MOD_RESET;
            reload_r <= 1'b0;
        end else begin
            reload_r <= 1'b0;
            if (wrStb && paddr == `TXIT_OFS_MODULUS) begin
                txIntervalModulus_r <= wrMerged;
                reload_r <= 1'b1;
            end
        end
    end

    // Control register write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= '{timerEnable: 1'b0, lineSel: txit_pkg::TXIT_LINE_NEITHER,
                        permitSet: 1'b0, usePll: 1'b0};
        end else if (wrStb && paddr == `TXIT_OFS_CONTROL && pstrb[0]) begin
            ctrl_r.timerEnable <= pwdata[`TXIT_CTL_EN_BIT];
            ctrl_r.lineSel <= txit_pkg::txit_line_sel_t'(pwdata[`TXIT_CTL_SEL_HI:`TXIT_CTL_SEL_LO]);
            ctrl_r.permitSet <= pwdata[`TXIT_CTL_PERMIT_BIT];
            ctrl_r.usePll <= pwdata[`TXIT_CTL_CLKSEL_BIT];
        end
    end

    // ----------------------------------------
    // Counter core
    // ----------------------------------------
    txit_counter uCounter (
        .ref_clk(ref_clk),
        .rst(rst),
        .tickEn(tickEn),
        .enable(ctrl_r.timerEnable),
        .reload(reload_r),
        .modulus(txIntervalModulus_r),
        .core(core)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            countSync_r <= `TXIT_CNT_RESET;
        end else begin
            countSync_r <= core.count;
        end
    end

    // ----------------------------------------
    // Transmit permit
    // ----------------------------------------
    // Packet-end clear synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clrSync1_r <= 1'b0;
            clrSync2_r <= 1'b0;
        end else begin
            clrSync1_r <= packetEndClear;
            clrSync2_r <= clrSync1_r;
        end
    end

    // Permit: restart set wins over packet clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            permit_r <= 1'b0;
        end else if (wrStb && paddr == `TXIT_OFS_CONTROL && pstrb[0]) begin
            // Software sets or drops permit directly
            permit_r <= pwdata[`TXIT_CTL_PERMIT_BIT];
        end else if (ctrl_r.lineSel == txit_pkg::TXIT_LINE_NEITHER
                     || ctrl_r.lineSel == txit_pkg::TXIT_LINE_TRISTATE) begin
            permit_r <= permit_r;
        end else if (core.restartPulse) begin
            permit_r <= 1'b1;
        end else if (clrSync2_r) begin
            permit_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            restart_r <= 1'b0;
            restartSeen_r <= 1'b0;
        end else begin
            restart_r <= core.restartPulse;
            if (core.restartPulse) begin
                restartSeen_r <= 1'b1;
            end else if (wrStb && paddr == `TXIT_OFS_STATUS && pstrb[0]
                         && pwdata[`TXIT_STS_RESTART_BIT]) begin
                restartSeen_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // APB read and answer
    // ----------------------------------------
    // Read multiplexer
    always_comb begin
        rdMux = 32'h00000000;
        unique case (paddr)
            `TXIT_OFS_MODULUS: begin
                rdMux = txIntervalModulus_r;
            end
            `TXIT_OFS_COUNT: begin
                rdMux = countSync_r;
            end
            `TXIT_OFS_CONTROL: begin
                rdMux[`TXIT_CTL_EN_BIT] = ctrl_r.timerEnable;
                rdMux[`TXIT_CTL_SEL_HI:`TXIT_CTL_SEL_LO] = ctrl_r.lineSel;
                rdMux[`TXIT_CTL_PERMIT_BIT] = ctrl_r.permitSet;
                rdMux[`TXIT_CTL_CLKSEL_BIT] = ctrl_r.usePll;
            end
            `TXIT_OFS_STATUS: begin
                rdMux[`TXIT_STS_PERMIT_BIT] = permit_r;
                rdMux[`TXIT_STS_RUN_BIT] = core.running;
                rdMux[`TXIT_STS_RESTART_BIT] = restartSeen_r;
            end
            default: begin
                rdMux = 32'h00000000;
            end
        endcase
    end

    // No wait state: answer in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata_r <= rdMux;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign transmitPermit = permit_r;
    assign restartPulse = restart_r;
endmodule // tx_restart_interval_timer

// ==== common/txit_cfg.svh ====
// Register offsets, reset values and timing constants of the interval timer
`ifndef TXIT_CFG_SVH
`define TXIT_CFG_SVH
`define TXIT_OFS_MODULUS 12'h000
`define TXIT_OFS_COUNT 12'h004
`define TXIT_OFS_CONTROL 12'h008
`define TXIT_OFS_STATUS 12'h00C
`define TXIT_MOD_RESET 32'hFFFFFFFF
`define TXIT_MOD_MIN 32'h00000005
`define TXIT_CNT_RESET 32'h00000000
`define TXIT_CTL_EN_BIT 0
`define TXIT_CTL_SEL_LO 1
`define TXIT_CTL_SEL_HI 2
`define TXIT_CTL_PERMIT_BIT 3
`define TXIT_CTL_CLKSEL_BIT 4
`define TXIT_STS_PERMIT_BIT 0
`define TXIT_STS_RUN_BIT 1
`define TXIT_STS_RESTART_BIT 2
`define TXIT_REF_HZ 32000000
`define TXIT_SYS_HZ 100000000
`define TXIT_DIV_W 4
`define TXIT_DIV_CYC (`TXIT_SYS_HZ / `TXIT_REF_HZ)
`endif

// ==== common/txit_pkg.sv ====
// Types shared by the interval timer files
package txit_pkg;
    // Transmit line control selection
    typedef enum logic [1:0] {
        TXIT_LINE_NEITHER,
        TXIT_LINE_TRISTATE,
        TXIT_LINE_GATED,
        TXIT_LINE_GATED_ALT
    } txit_line_sel_t;

    // Software control fields
    typedef struct packed {
        logic timerEnable;
        txit_line_sel_t lineSel;
        logic permitSet;
        logic usePll;
    } txit_ctrl_t;

    // Counter core state seen by the host side
    typedef struct packed {
        logic running;
        logic restartPulse;
        logic [31:0] count;
    } txit_core_t;
endpackage

// ==== rtl/txit_counter.sv ====
// Interval counter core running on channel-clock enables
`timescale 1ns/1ps
`include "txit_cfg.svh"
module txit_counter (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tickEn,
    input wire logic enable,
    input wire logic reload,
    input wire logic [31:0] modulus,
    output txit_pkg::txit_core_t core
);
    // Core register and next value
    txit_pkg::txit_core_t core_r;
    txit_pkg::txit_core_t core_nxt;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        core_nxt = core_r;
        core_nxt.restartPulse = 1'b0;
        core_nxt.running = enable;
        if (!enable) begin
            // Idle: hold modulus ready for the start
            core_nxt.count = modulus;
        end else if (reload || !core_r.running) begin
            core_nxt.count = modulus;
        end else if (tickEn) begin
            if (core_r.count <= 32'h00000001) begin
                core_nxt.count = modulus;
                core_nxt.restartPulse = 1'b1;
            end else begin
                core_nxt.count = core_r.count - 32'h00000001;
            end
        end
    end

    // Core state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_r <= '{running: 1'b0, restartPulse: 1'b0, count: `TXIT_CNT_RESET};
        end else begin
            core_r <= core_nxt;
        end
    end

    assign core = core_r;
endmodule // txit_counter

// ==== test/txit_chk.sv ====
// Port checker for the transmit interval timer
`timescale 1ns/1ps
`include "txit_cfg.svh"
module txit_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic transmitPermit,
    input wire logic restartPulse
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic en_r;
    logic gated_r;
    wire logic ctlWr = psel && !penable && pwrite && paddr == `TXIT_OFS_CONTROL && pstrb[0];
    wire logic mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
    // Mirror enable and gated selection from control writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_r <= 1'b0;
            gated_r <= 1'b0;
        end else if (ctlWr) begin
            en_r <= pwdata[0];
            gated_r <= pwdata[2];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ready_follows: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_access: assert property (pready |-> psel && penable && !$past(penable))
        else $error("pready outside access phase");
    a_mapped_ok: assert property (s_setup ##0 mapped |=> !pslverr)
        else $error("error on mapped address");
    // Read data is only answered for reads; a write leaves it alone
    a_unmapped_err: assert property (s_setup ##0 !mapped
        |=> pslverr && (pwrite || prdata == 32'h00000000))
        else $error("unmapped access not refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pulse_single: assert property (restartPulse |=> !restartPulse [*2])
        else $error("restart pulse too long");
    a_pulse_enabled: assert property (restartPulse |-> $past(en_r, 2))
        else $error("restart pulse while disabled");
    a_permit_restart: assert property (restartPulse && gated_r |-> ##[0:1] transmitPermit)
        else $error("restart did not set permit");
    a_free_permit: assert property (!gated_r && $rose(transmitPermit) |-> $past(ctlWr))
        else $error("permit rose in free mode");
endmodule // txit_chk
bind tx_restart_interval_timer txit_chk chk_u (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmitPermit(transmitPermit), .restartPulse(restartPulse)
);

// ==== test/tx_restart_interval_timer_tb_top.sv ====
// Self-checking bench for the transmit interval timer
`timescale 1ns/1ps
`include "txit_cfg.svh"
module tx_restart_interval_timer_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic pllTick = 1'b0;
    logic packetEndClear = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, transmitPermit, restartPulse;
    logic pllOn = 1'b0;
    logic [2:0] pllDiv = 3'h0;
    logic [31:0] seed = 32'h92922F5F;
    logic [31:0] rd, modv, c1;
    logic err;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int t1, t2;
    always #5 ref_clk = ~ref_clk;
    // Cycle count and hang limit
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // Channel clock stand-in: one rising edge every eight cycles
    always @(posedge ref_clk) begin
        pllDiv <= pllOn ? pllDiv + 3'h1 : 3'h0;
        pllTick <= pllOn && pllDiv[2];
    end
    tx_restart_interval_timer dut_u (
        .ref_clk(ref_clk), .rst(rst), .pllTick(pllTick), .packetEndClear(packetEndClear),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transmitPermit(transmitPermit), .restartPulse(restartPulse)
    );
    function logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Byte-strobe merge of a modulus write
    function logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
        for (int i = 0; i < 4; i++) merge[8*i +: 8] = b[i] ? n[8*i +: 8] : o[8*i +: 8];
    endfunction
    function int period(input logic [31:0] m, input int tick);
        return m * tick;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task wait_pulse(output int t);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (restartPulse !== 1'b1 && n < 2000);
        // A pulse that never comes counts against the run
        if (restartPulse !== 1'b1) fail_count++;
        t = cyc;
    endtask
    task end_test(input string s);
        $display("test %s done", s);
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, `TXIT_OFS_MODULUS, 32'h0, rd, err);
        check(rd, `TXIT_MOD_RESET); // modulus reset value
        apb(1'b0, `TXIT_OFS_COUNT, 32'h0, rd, err);
        check(rd, `TXIT_MOD_RESET); // idle count shows modulus
        end_test("reset");
        modv = `TXIT_MOD_RESET;
        repeat (8) begin
            seed = lfsr_next(seed);
            pstrb <= seed[3:0];
            apb(1'b1, `TXIT_OFS_MODULUS, seed, rd, err);
            modv = merge(modv, seed, seed[3:0]);
            pstrb <= 4'hF;
            apb(1'b0, `TXIT_OFS_MODULUS, 32'h0, rd, err);
            check(rd, modv); // modulus read back
        end
        apb(1'b1, `TXIT_OFS_COUNT, seed, rd, err);
        check(32'(err), 32'h0); // count write accepted
        apb(1'b0, `TXIT_OFS_COUNT, 32'h0, rd, err);
        check(rd, modv); // count is read-only
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check(rd, 32'h00000000); // unmapped read returns zero
        check(32'(err), 32'h1); // unmapped read refused
        end_test("registers");
        modv = `TXIT_MOD_MIN + 32'(seed[2:0]); // modulus at least five
        apb(1'b1, `TXIT_OFS_MODULUS, modv, rd, err);
        apb(1'b1, `TXIT_OFS_CONTROL, 32'h5, rd, err);
        wait_pulse(t1);
        wait_pulse(t2);
        check(t2 - t1, period(modv, `TXIT_DIV_CYC)); // period in ticks
        repeat (2) @(posedge ref_clk);
        check(32'(transmitPermit), 32'h1); // restart sets permit
        // Status: permit, running and restart seen all set
        apb(1'b0, `TXIT_OFS_STATUS, 32'h0, rd, err);
        check(rd, 32'h00000007); // status after restart
        apb(1'b0, `TXIT_OFS_CONTROL, 32'h0, rd, err);
        check(rd, 32'h00000005); // control read back
        apb(1'b1, `TXIT_OFS_MODULUS, 32'h28, rd, err);
        apb(1'b0, `TXIT_OFS_COUNT, 32'h0, c1, err);
        check(32'(c1 <= 32'h28 && c1 >= 32'h24), 32'h1); // write reloads count
        apb(1'b0, `TXIT_OFS_COUNT, 32'h0, c1, err);
        repeat (27) @(posedge ref_clk);
        apb(1'b0, `TXIT_OFS_COUNT, 32'h0, rd, err);
        check(c1 - rd, 32'hA); // read count tracks ticks
        wait_pulse(t1);
        packetEndClear <= 1'b1;
        repeat (3) @(posedge ref_clk);
        packetEndClear <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(32'(transmitPermit), 32'h0); // packet end drops permit
        wait_pulse(t1);
        repeat (2) @(posedge ref_clk);
        check(32'(transmitPermit), 32'h1); // timer restores permit
        end_test("gated");
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `TXIT_OFS_CONTROL, 32'(1 + 2 * s), rd, err);
            apb(1'b1, `TXIT_OFS_MODULUS, 32'h5, rd, err);
            wait_pulse(t1);
            wait_pulse(t2);
            check(t2 - t1, period(5, `TXIT_DIV_CYC)); // timer runs freely
            check(32'(transmitPermit), 32'h0); // permit left alone
        end
        end_test("free");
        pllOn <= 1'b1;
        apb(1'b1, `TXIT_OFS_CONTROL, 32'h11, rd, err);
        wait_pulse(t1);
        wait_pulse(t2);
        check(t2 - t1, period(5, 8)); // channel clock rate
        pllOn <= 1'b0;
        apb(1'b1, `TXIT_OFS_CONTROL, 32'h0, rd, err);
        end_test("pll");
        tally_and_finish();
    end
endmodule // tx_restart_interval_timer_tb_top
